// ### common/pmpc_pkg.sv
// constants and types for the module mode and pwm configuration block
// assumes a 32-bit axi4-lite master and an 8-bit register file behind it
`default_nettype none
package pmpc_pkg;
    // ==========================================================
    // register indices (byte address is four times the index)
    localparam int         NUM_MODULES     = 6;
    localparam int         WATCHDOG_MODULE = 5;
    localparam int         ADDR_W          = 32;
    localparam logic [7:0] IDX_PWM_CFG     = 8'hdf;
    localparam logic [7:0] IDX_CTRL        = 8'hc0;   // watchdog enable
    localparam logic [7:0] IDX_FLAGS       = 8'hc1;   // module event flags
    localparam logic [7:0] IDX_MODE [0:5]  = '{8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hce};
    localparam logic [7:0] IDX_LOW  [0:5]  = '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd, 8'hd2};
    localparam logic [7:0] IDX_HIGH [0:5]  = '{8'hfc, 8'hea, 8'hec, 8'hee, 8'hfe, 8'hd3};
    // ==========================================================
    // field positions and reset values
    localparam int         CTRL_WDOG_BIT   = 0;
    localparam logic [7:0] MODE_RESET      = 8'h00;
    localparam logic [7:0] PWM_CFG_RESET   = 8'h00;
    localparam logic [2:0] PWM_CFG_UNUSED  = 3'h0;
    localparam logic [1:0] CLSEL_8BIT      = 2'h0;
    localparam int         BASE_CYCLE_BITS = 8;
    localparam int         MAX_CYCLE_BITS  = 11;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_DECERR     = 2'h3;
    // ==========================================================
    // per-module mode byte
    typedef struct packed {
        logic wide_pwm_select;
        logic comparator_enable;
        logic rising_capture_enable;
        logic falling_capture_enable;
        logic match_enable;
        logic toggle_enable;
        logic pwm_enable;
        logic module_flag_irq_enable;
    } pmpc_mode_t;
    // shared pwm configuration byte
    typedef struct packed {
        logic       reload_register_select;
        logic       cycle_overflow_irq_enable;
        logic       cycle_overflow_flag;
        logic [2:0] unused;
        logic [1:0] cycle_length_select;
    } pmpc_pwm_cfg_t;
    // decoded register kind
    typedef enum logic [2:0] {
        K_NONE, K_MODE, K_LOW, K_HIGH, K_PWM, K_CTRL, K_FLAGS
    } pmpc_kind_t;
    typedef struct packed {
        pmpc_kind_t kind;
        logic [2:0] mod;
    } pmpc_dec_t;
endpackage
`default_nettype wire

// ### hdl/pmpc_top.sv
// six capture/compare module configuration, pwm and event logic with axi4-lite registers
// assumes the main counter and its count tick come from logic on the same clock
`default_nettype none
// Function
// - reload select steers value register accesses
// - reload values used only in 9-11 bit pwm
// - cycle overflow irq gated by its enable
// - overflow flag set at selected counter bit
// - overflow flag set by hardware or software
// - pwm config bits 4:2 read zero
// - cycle length 00/01/10 give 8/9/10 bits
// - cycle length ignored in 16-bit pwm
// - wide select picks 8-11 or 16-bit pwm
// - comparator works only when enabled
// - rising pin edge captures counter value
// - falling pin edge captures counter value
// - match sets module event flag
// - toggle enable inverts pin on match
// - toggle plus pwm gives frequency output
// - pwm enable drives pwm on pin
// - module flag irq gated by its enable
// - watchdog enable locks module 5 mode
// - hardware only sets module event flags
// - low value write clears comparator enable
// - high value write sets comparator enable
module pmpc_top #(
    parameter int NMOD = pmpc_pkg::NUM_MODULES
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [pmpc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [pmpc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic [15:0]                 main_counter,
    input  wire logic                        count_tick,
    input  wire logic [NMOD-1:0]             module_pin_in,
    output logic [NMOD-1:0]                  module_output_pin,
    output logic                             counter_array_irq
);
    import pmpc_pkg::*;

    // ==========================================================
    // helpers
    // address to register kind and module number
    function automatic pmpc_dec_t decode(input logic [ADDR_W-1:0] addr);
        pmpc_dec_t d;
        d = '{kind: K_NONE, mod: 3'h0};
        if (addr[ADDR_W-1:10] != '0 || addr[1:0] != 2'h0) begin
            d.kind = K_NONE;
        end else if (addr[9:2] == IDX_PWM_CFG) begin
            d.kind = K_PWM;
        end else if (addr[9:2] == IDX_CTRL) begin
            d.kind = K_CTRL;
        end else if (addr[9:2] == IDX_FLAGS) begin
            d.kind = K_FLAGS;
        end else begin
            for (int m = 0; m < NUM_MODULES; m++) begin
                if (addr[9:2] == IDX_MODE[m]) begin
                    d = '{kind: K_MODE, mod: 3'(m)};
                end else if (addr[9:2] == IDX_LOW[m]) begin
                    d = '{kind: K_LOW, mod: 3'(m)};
                end else if (addr[9:2] == IDX_HIGH[m]) begin
                    d = '{kind: K_HIGH, mod: 3'(m)};
                end
            end
        end
        return d;
    endfunction

    // low-bit mask for the selected cycle length
    function automatic logic [10:0] cycle_mask(input logic [1:0] clsel);
        return 11'((12'h1 << (BASE_CYCLE_BITS + int'(clsel))) - 12'h1);
    endfunction

    // ==========================================================
    // register state
    pmpc_mode_t    mode_reg  [NMOD];     // per-module mode
    logic [15:0]   cc_reg    [NMOD];     // capture/compare values
    logic [15:0]   rl_reg    [NMOD];     // auto-reload values
    logic [10:0]   duty_reg  [NMOD];     // latched 8-11 bit duty
    pmpc_pwm_cfg_t pwm_reg;              // shared pwm configuration
    logic          wdog_reg;             // watchdog owns module 5
    logic [NMOD-1:0] flag_reg;           // module event flags
    logic [NMOD-1:0] pin_reg;            // module output pins
    logic          irq_reg;              // interrupt request

    // ==========================================================
    // axi4-lite write channel
    logic              aw_rdy_reg, w_rdy_reg, aw_held_reg, w_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [7:0]        w_data_reg;
    logic              w_strb_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    pmpc_dec_t         wdec;             // decoded write target
    logic              do_write;         // one-cycle register write

    assign wdec     = decode(aw_addr_reg);
    assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;

    // address and data are taken in either order, then held until the write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_rdy_reg  <= 1'b0;
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && aw_rdy_reg) begin
            aw_rdy_reg  <= 1'b0;
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end else if (!aw_held_reg && !bvalid_reg) begin
            aw_rdy_reg  <= 1'b1;         // re-arm once the response is gone
        end
    end

    // write data side, only byte lane 0 carries a register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_rdy_reg  <= 1'b0;
            w_held_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_strb_reg <= 1'b0;
        end else if (s_axi_wvalid && w_rdy_reg) begin
            w_rdy_reg  <= 1'b0;
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_strb_reg <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end else if (!w_held_reg && !bvalid_reg) begin
            w_rdy_reg  <= 1'b1;
        end
    end

    // response one cycle after both halves are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wdec.kind == K_NONE) ? RESP_DECERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // write enables; a clear wstrb[0] makes the write a no-op
    logic we;
    assign we = do_write & w_strb_reg;

    // ==========================================================
    // axi4-lite read channel
    logic        ar_rdy_reg, rvalid_reg;
    logic [7:0]  rdata_reg;
    logic [1:0]  rresp_reg;
    pmpc_dec_t   rdec;
    logic [7:0]  rd_byte;                // combinational read mux

    assign rdec = decode(s_axi_araddr);

    // read mux; value registers follow the reload select
    always_comb begin
        rd_byte = 8'h00;
        case (rdec.kind)
            K_MODE:  rd_byte = mode_reg[rdec.mod];
            K_LOW:   rd_byte = pwm_reg.reload_register_select ?
                               rl_reg[rdec.mod][7:0] : cc_reg[rdec.mod][7:0];
            K_HIGH:  rd_byte = pwm_reg.reload_register_select ?
                               rl_reg[rdec.mod][15:8] : cc_reg[rdec.mod][15:8];
            K_PWM:   rd_byte = {pwm_reg[7:5], PWM_CFG_UNUSED, pwm_reg[1:0]};
            K_CTRL:  rd_byte = {7'h00, wdog_reg};
            K_FLAGS: rd_byte = 8'(flag_reg);
            default: rd_byte = 8'h00;
        endcase
    end

    // single read in flight; data latched at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_rdy_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg  <= 8'h00;
            rresp_reg  <= RESP_OKAY;
        end else if (s_axi_arvalid && ar_rdy_reg) begin
            ar_rdy_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_byte;
            rresp_reg  <= (rdec.kind == K_NONE) ? RESP_DECERR : RESP_OKAY;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end else if (!rvalid_reg) begin
            ar_rdy_reg <= 1'b1;
        end
    end

    // ==========================================================
    // pin synchronisers and edge detection
    logic [NMOD-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
    logic [NMOD-1:0] rise_ev, fall_ev;

    // first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
        end else begin
            pin_s1_reg <= module_pin_in;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    assign rise_ev = pin_s2_reg & ~pin_s3_reg;
    assign fall_ev = ~pin_s2_reg & pin_s3_reg;

    // ==========================================================
    // per-module event terms
    logic [10:0]     cmask;              // cycle length mask
    logic            ov_hit;             // counter leaves selected bit
    logic [NMOD-1:0] cap_ev, match_ev, flag_set, freq_ev;

    assign cmask  = cycle_mask(pwm_reg.cycle_length_select);
    assign ov_hit = count_tick & ((main_counter[10:0] & cmask) == cmask);

    always_comb begin
        for (int m = 0; m < NMOD; m++) begin
            cap_ev[m]   = (mode_reg[m].rising_capture_enable & rise_ev[m])
                        | (mode_reg[m].falling_capture_enable & fall_ev[m]);
            // comparator is silent unless enabled
            match_ev[m] = mode_reg[m].comparator_enable & count_tick
                        & (main_counter == cc_reg[m]);
            freq_ev[m]  = mode_reg[m].comparator_enable & count_tick
                        & (main_counter[7:0] == cc_reg[m][7:0]);
            flag_set[m] = cap_ev[m] | (match_ev[m] & mode_reg[m].match_enable);
        end
    end

    // ==========================================================
    // mode registers, including value-write side effects
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int m = 0; m < NMOD; m++) mode_reg[m] <= MODE_RESET;
        end else if (we && !(wdog_reg && int'(wdec.mod) == WATCHDOG_MODULE)) begin
            // a locked module 5 also keeps its comparator enable on value writes
            if (wdec.kind == K_MODE) begin
                mode_reg[wdec.mod] <= w_data_reg;
            end else if (wdec.kind == K_LOW) begin
                mode_reg[wdec.mod].comparator_enable <= 1'b0;
            end else if (wdec.kind == K_HIGH) begin
                mode_reg[wdec.mod].comparator_enable <= 1'b1;
            end
        end
    end

    // value registers; a capture takes priority over a software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int m = 0; m < NMOD; m++) begin
                cc_reg[m] <= 16'h0000;
                rl_reg[m] <= 16'h0000;
            end
        end else begin
            if (we && (wdec.kind == K_LOW || wdec.kind == K_HIGH)) begin
                if (pwm_reg.reload_register_select) begin
                    if (wdec.kind == K_LOW) rl_reg[wdec.mod][7:0]  <= w_data_reg;
                    else                    rl_reg[wdec.mod][15:8] <= w_data_reg;
                end else begin
                    if (wdec.kind == K_LOW) cc_reg[wdec.mod][7:0]  <= w_data_reg;
                    else                    cc_reg[wdec.mod][15:8] <= w_data_reg;
                end
            end
            for (int m = 0; m < NMOD; m++) begin
                if (cap_ev[m]) cc_reg[m] <= main_counter;
            end
        end
    end

    // pwm configuration; hardware set of the overflow flag wins over a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_reg <= PWM_CFG_RESET;
        end else begin
            if (we && wdec.kind == K_PWM) begin
                pwm_reg <= {w_data_reg[7:5], PWM_CFG_UNUSED, w_data_reg[1:0]};
            end
            if (ov_hit) pwm_reg.cycle_overflow_flag <= 1'b1;
        end
    end

    // watchdog ownership of module 5 and the module event flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdog_reg <= 1'b0;
            flag_reg <= '0;
        end else begin
            if (we && wdec.kind == K_CTRL) wdog_reg <= w_data_reg[CTRL_WDOG_BIT];
            // write one to clear, then hardware sets on top
            flag_reg <= ((we && wdec.kind == K_FLAGS) ?
                         (flag_reg & ~w_data_reg[NMOD-1:0]) : flag_reg)
                        | flag_set;
        end
    end

    // ==========================================================
    // duty latch: reload values only matter in 9-11 bit cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int m = 0; m < NMOD; m++) duty_reg[m] <= 11'h000;
        end else if (ov_hit) begin
            for (int m = 0; m < NMOD; m++) begin
                duty_reg[m] <= (pwm_reg.cycle_length_select == CLSEL_8BIT) ?
                               {3'h0, cc_reg[m][15:8]} : rl_reg[m][10:0];
            end
        end
    end

    // output pins: pwm, frequency output or toggle on match
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_reg <= '0;
        end else begin
            for (int m = 0; m < NMOD; m++) begin
                if (mode_reg[m].pwm_enable && mode_reg[m].toggle_enable) begin
                    if (freq_ev[m]) pin_reg[m] <= ~pin_reg[m];
                end else if (mode_reg[m].pwm_enable && mode_reg[m].comparator_enable) begin
                    if (mode_reg[m].wide_pwm_select) begin
                        pin_reg[m] <= (main_counter >= cc_reg[m]);
                    end else begin
                        pin_reg[m] <= ((main_counter[10:0] & cmask) >= duty_reg[m]);
                    end
                end else if (mode_reg[m].toggle_enable && match_ev[m]) begin
                    pin_reg[m] <= ~pin_reg[m];
                end
            end
        end
    end

    // interrupt request from flags gated by their enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (pwm_reg.cycle_overflow_flag & pwm_reg.cycle_overflow_irq_enable)
                     | (|(flag_reg & {mode_reg[5].module_flag_irq_enable,
                                      mode_reg[4].module_flag_irq_enable,
                                      mode_reg[3].module_flag_irq_enable,
                                      mode_reg[2].module_flag_irq_enable,
                                      mode_reg[1].module_flag_irq_enable,
                                      mode_reg[0].module_flag_irq_enable}));
        end
    end

    // ==========================================================
    // outputs straight from flip-flops
    assign s_axi_awready     = aw_rdy_reg;
    assign s_axi_wready      = w_rdy_reg;
    assign s_axi_bvalid      = bvalid_reg;
    assign s_axi_bresp       = bresp_reg;
    assign s_axi_arready     = ar_rdy_reg;
    assign s_axi_rvalid      = rvalid_reg;
    assign s_axi_rdata       = {24'h000000, rdata_reg};
    assign s_axi_rresp       = rresp_reg;
    assign module_output_pin = pin_reg;
    assign counter_array_irq = irq_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic pwm_wr, rd_pwm;
    assign pwm_wr = we && wdec.kind == K_PWM;
    assign rd_pwm = s_axi_arvalid && ar_rdy_reg && rdec.kind == K_PWM;

    cycle_overflow_flag_set_a: assert property (ov_hit |=> pwm_reg.cycle_overflow_flag)
        else $error("overflow flag not set after overflow");
    cycle_overflow_flag_hold_a: assert property (pwm_reg.cycle_overflow_flag && !pwm_wr
        |=> pwm_reg.cycle_overflow_flag)
        else $error("overflow flag cleared by hardware");
    pwm_rsvd_a: assert property (rd_pwm |=> s_axi_rvalid && s_axi_rdata[4:2] == 3'h0)
        else $error("unused pwm config bits read nonzero");
    irq_ovf_a: assert property (pwm_reg.cycle_overflow_flag
        && pwm_reg.cycle_overflow_irq_enable |=> counter_array_irq)
        else $error("overflow interrupt missing");
    wdog_lock_a: assert property (wdog_reg |=> $stable(mode_reg[5]))
        else $error("module 5 mode changed under watchdog");
    low_clear_a: assert property (we && wdec.kind == K_LOW && wdec.mod == 3'h0
        |=> !mode_reg[0].comparator_enable)
        else $error("low write did not clear comparator enable");
    high_set_a: assert property (we && wdec.kind == K_HIGH && wdec.mod == 3'h0
        |=> mode_reg[0].comparator_enable)
        else $error("high write did not set comparator enable");
    match_flag_a: assert property (match_ev[0] && mode_reg[0].match_enable
        |=> flag_reg[0] ##1 counter_array_irq || !mode_reg[0].module_flag_irq_enable)
        else $error("match did not set flag or interrupt");
    wide_pwm_a: assert property (mode_reg[0].pwm_enable && mode_reg[0].wide_pwm_select
        && mode_reg[0].comparator_enable && !mode_reg[0].toggle_enable
        |=> module_output_pin[0] == ($past(main_counter) >= $past(cc_reg[0])))
        else $error("16-bit pwm level wrong");
endmodule
`default_nettype wire

// ### verification/pmpc_far_model.sv
// far-side model: main counter, count tick and external module pins
// assumes one clock shared with the register block under test
`default_nettype none
module pmpc_far_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    output var  logic [15:0] main_counter,
    output var  logic        count_tick,
    output var  logic [5:0]  pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // counter source
    initial {main_counter, count_tick, pin} = '0;
    // one tick every clock keeps overflow points easy to predict
    always @(posedge aclk) begin
        count_tick   <= aresetn;
        main_counter <= aresetn ? main_counter + 16'h1 : 16'h0;
        // square wave, period 64, so both pin edges keep coming
        pin          <= aresetn ? {6{main_counter[5]}} : 6'h00;
    end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench: register map model, overflow and capture events
// assumes the far-side model drives counter, tick and pins
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    import pmpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // bus signals and counters
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_bvalid, s_axi_rvalid;
    logic        s_axi_awready, s_axi_wready, s_axi_arready, counter_array_irq, count_tick;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] main_counter;
    logic [5:0]  module_pin_in, module_output_pin;
    logic [31:0] xs_state = 32'h00000860;  // seed 2144
    int          mdl[int] = '{default: 0};  // reference register map
    int          fail_count = 0, check_count = 0, wd = 0, m;
    pmpc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .main_counter,
        .count_tick, .module_pin_in, .module_output_pin, .counter_array_irq);
    pmpc_far_model far (.aclk, .aresetn, .main_counter, .count_tick, .pin(module_pin_in));
    always #5 aclk = ~aclk;
    // ==========================================================
    // helpers
    function automatic logic [31:0] xs();
        xs_state ^= xs_state << 13;
        xs_state ^= xs_state >> 17;
        xs_state ^= xs_state << 5;
        return xs_state;
    endfunction
    // value registers alias two stores, picked by the reload select bit
    function automatic int key(input logic [7:0] i);
        if (i inside {[8'he9:8'hee], [8'hfb:8'hfe], 8'hd2, 8'hd3})
            return i + 256 * mdl[IDX_PWM_CFG][7];
        return i;
    endfunction
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {22'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        fork
            begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'h0; end
            begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'h0; end
        join
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        // model update: side effects on the mode bytes first
        for (int i = 0; i < 6; i++) begin
            if (i == 5 && wd != 0) continue;
            if (idx == IDX_LOW[i]) mdl[IDX_MODE[i]] &= 'hbf;
            if (idx == IDX_HIGH[i]) mdl[IDX_MODE[i]] |= 'h40;
        end
        if (idx == IDX_MODE[5] && wd != 0) d = 8'(mdl[idx]);
        if (idx == IDX_CTRL) wd = d[0];
        mdl[key(idx)] = (idx == IDX_PWM_CFG) ? d & 8'he3 : d;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] msk, input logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= {22'h0, idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        `CHK(s_axi_rresp, rs)
        `CHK(s_axi_rdata & {24'h0, msk}, 32'(mdl[key(idx)] & msk))
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // hang guard, far beyond the longest overflow wait
    initial begin
        repeat (60000) @(posedge aclk);
        fail_count++;
        test_done();
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        rd(IDX_PWM_CFG, 8'hff, RESP_OKAY);
        // reset value, then a random byte read back whole
        for (int i = 0; i < 6; i++) begin
            rd(IDX_MODE[i], 8'hff, RESP_OKAY);
            wr(IDX_MODE[i], 8'(xs()));
            rd(IDX_MODE[i], 8'hff, RESP_OKAY);
        end
        wr(IDX_PWM_CFG, 8'hdf);
        rd(IDX_PWM_CFG, 8'hdf, RESP_OKAY);
        rd(8'h00, 8'hff, RESP_DECERR);
        $display("test 1 done");
        wr(IDX_MODE[0], 8'h40);
        wr(IDX_LOW[0], 8'h12);
        rd(IDX_MODE[0], 8'hff, RESP_OKAY);
        wr(IDX_HIGH[0], 8'h34);
        rd(IDX_MODE[0], 8'hff, RESP_OKAY);
        wr(IDX_PWM_CFG, 8'h80);
        wr(IDX_LOW[0], 8'h56);
        rd(IDX_LOW[0], 8'hff, RESP_OKAY);
        wr(IDX_PWM_CFG, 8'h00);
        // earlier random modes may have captured into the compare value
        wr(IDX_LOW[0], 8'ha5);
        rd(IDX_LOW[0], 8'hff, RESP_OKAY);
        wr(IDX_PWM_CFG, 8'h80);
        rd(IDX_LOW[0], 8'hff, RESP_OKAY);
        wr(IDX_CTRL, 8'h01);
        wr(IDX_MODE[5], 8'h5a);
        rd(IDX_MODE[5], 8'hff, RESP_OKAY);
        wr(IDX_CTRL, 8'h00);
        wr(IDX_MODE[5], 8'h5a);
        rd(IDX_MODE[5], 8'hff, RESP_OKAY);
        $display("test 2 done");
        // quiet modules so only the cycle overflow can interrupt
        for (int i = 0; i < 6; i++) wr(IDX_MODE[i], 8'h00);
        wr(IDX_FLAGS, 8'h3f);
        for (int c = 0; c < 4; c++) begin
            m = (1 << (8 + c)) - 1;
            while ((main_counter & m) != 16) @(posedge aclk);
            wr(IDX_PWM_CFG, 8'(8'h40 | c));
            while ((main_counter & m) != m - 4) @(posedge aclk);
            `CHK(counter_array_irq, 1'h0)
            repeat (8) @(posedge aclk);
            `CHK(counter_array_irq, 1'h1)
            mdl[IDX_PWM_CFG] = 'h60 | c;
            rd(IDX_PWM_CFG, 8'hff, RESP_OKAY);
        end
        $display("test 3 done");
        wr(IDX_PWM_CFG, 8'h00);
        wr(IDX_MODE[1], 8'h21);
        repeat (150) @(posedge aclk);
        `CHK(counter_array_irq, 1'h1)
        wr(IDX_MODE[1], 8'h10);
        wr(IDX_FLAGS, 8'h02);
        repeat (150) @(posedge aclk);
        `CHK(counter_array_irq, 1'h0)
        mdl[IDX_FLAGS] = 'h02;  // falling edges set the flag again
        rd(IDX_FLAGS, 8'h02, RESP_OKAY);
        // 8-bit pwm on module 2: pin high once the low byte reaches duty 0x80
        wr(IDX_HIGH[2], 8'h80);
        wr(IDX_MODE[2], 8'h42);
        repeat (256) @(posedge aclk);
        while ((main_counter & 'hff) != 'h10) @(posedge aclk);
        `CHK(module_output_pin[2], 1'h0)
        while ((main_counter & 'hff) != 'h90) @(posedge aclk);
        `CHK(module_output_pin[2], 1'h1)
        $display("test 4 done");
        test_done();
    end
endmodule
`default_nettype wire
